// ==== src/pfg_fault_guard.sv ====
// Fault qualification, disable mapping and software override of six PWM pins.
//
// Behaviour
// [R1] Fault input counts only when enabled.
// [R2] Flag sets after configured qualifying samples.
// [R3] Write one clears flag, zero keeps.
// [R4] Detection runs regardless of PWM enable.
// [R5] Clearing flag withdraws its interrupt request.
// [R6] First sample at two, then every four.
// [R7] Sample code selects 1,5,10,15 samples.
// [R8] Enabled fault disables mapped pins immediately.
// [R9] Protected registers ignore writes once locked.
// [R10] Each pin has own four-bit map.
// [R11] Map bit j is fault j; inactive.
// [R12] Override drives pin from level bit.
// [R13] Software keeps pair override bits equal.
// [R14] Independent override: level bit sets pin.
// [R15] Complementary odd pin complements even or off.
// [R16] Clear-select bit: manual or automatic clearing.
// [R17] Irq enable gates only the interrupt.
`timescale 1ns/1ps
module pfg_fault_guard #(
  parameter int NFAULT = 4,
  parameter int NPWM = 6
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] fault_input,
  input wire pfg_pkg::pfg_pins_s pwm_pins_in,
  output pfg_pkg::pfg_pins_s pwm_pins_out,
  output logic [5:0] pin_disable,
  output logic irq
);
  import pfg_pkg::*;

  // The pin map and register packing are hard-wired, so other sizes are refused at elaboration.
  if (NFAULT != 4 || NPWM != 6) begin : g_bad_size
    $error("Only four faults and six pins are supported.");
  end

  // ********************************************************************
  // Bus slave.
  // ********************************************************************
  // One wait state per access keeps read data registered.
  logic ack_q;
  logic [3:0] idx;
  logic wr_hit;
  logic [7:0] wb;
  logic [7:0] fctl_q, fen_q, fault_filter_count_q, dma_q, dmb_q, dmc_q, ovr_q, lvl_q, mode_q, imask_q;
  logic [3:0] flag_q, flag_d, istat_q;
  logic locked;

  assign idx = avs_address[5:2];
  assign wb = avs_writedata[7:0];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_hit = avs_write & ack_q;
  assign locked = mode_q[LOCK_BIT];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      case (idx)
        IDX_FAULT_CTRL: avs_readdata <= {24'h000000, fctl_q};
        IDX_FAULT_INPUT_ENABLE: avs_readdata <= {24'h000000, fen_q}; // R9
        IDX_FAULT_STATUS_FLAGS: avs_readdata <= {24'h000000, 1'b0, flag_q[3], 1'b0, flag_q[2],
                                                 1'b0, flag_q[1], 1'b0, flag_q[0]};
        IDX_FAULT_SAMPLE_COUNT: avs_readdata <= {24'h000000, fault_filter_count_q};
        IDX_DISABLE_MAP_PAIR_A: avs_readdata <= {24'h000000, dma_q};
        IDX_DISABLE_MAP_PAIR_B: avs_readdata <= {24'h000000, dmb_q};
        IDX_DISABLE_MAP_PAIR_C: avs_readdata <= {24'h000000, dmc_q};
        IDX_SOFT_OVERRIDE_ENABLE: avs_readdata <= {24'h000000, ovr_q};
        IDX_LOCK_MODE: avs_readdata <= {24'h000000, mode_q};
        IDX_SOFT_DRIVE_LEVEL: avs_readdata <= {24'h000000, lvl_q};
        IDX_IRQ_STATUS: avs_readdata <= {28'h0000000, istat_q};
        IDX_IRQ_MASK: avs_readdata <= {24'h000000, imask_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ********************************************************************
  // Configuration registers.
  // ********************************************************************
  // The lock bit is write-once: only reset clears it.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fctl_q <= RST_BYTE;
      fen_q <= RST_BYTE;
      fault_filter_count_q <= RST_BYTE;
      dma_q <= RST_BYTE;
      dmb_q <= RST_BYTE;
      dmc_q <= RST_BYTE;
      ovr_q <= RST_BYTE;
      lvl_q <= RST_BYTE;
      mode_q <= RST_BYTE;
      imask_q <= RST_BYTE;
    end else if (wr_hit) begin
      case (idx)
        IDX_FAULT_CTRL: fctl_q <= wb;
        IDX_FAULT_INPUT_ENABLE: if (!locked) fen_q <= {4'h0, wb[3:0]}; // R9
        IDX_FAULT_SAMPLE_COUNT: if (!locked) fault_filter_count_q <= wb; // R9
        IDX_DISABLE_MAP_PAIR_A: if (!locked) dma_q <= wb; // R9
        IDX_DISABLE_MAP_PAIR_B: if (!locked) dmb_q <= wb; // R9
        IDX_DISABLE_MAP_PAIR_C: if (!locked) dmc_q <= wb; // R9
        IDX_SOFT_OVERRIDE_ENABLE: ovr_q <= {2'b00, wb[5:0]};
        IDX_LOCK_MODE: mode_q <= {6'h00, wb[COMPL_BIT], wb[LOCK_BIT] | mode_q[LOCK_BIT]};
        IDX_SOFT_DRIVE_LEVEL: lvl_q <= {2'b00, wb[5:0]};
        IDX_IRQ_MASK: imask_q <= {4'h0, wb[3:0]};
        default: ;
      endcase
    end
  end

  // ********************************************************************
  // Fault qualification.
  // ********************************************************************
  logic [3:0] fin_q, qualified, fen;
  logic [2:0] tick_q [4];
  logic [3:0] cnt_q [4];
  logic [3:0] need [4];
  pfg_qual_e st_q [4];

  assign fen = fen_q[3:0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fin_q <= 4'h0;
    end else begin
      fin_q <= fault_input;
    end
  end

  for (genvar f = 0; f < 4; f++) begin : g_qual
    always_comb begin
      case (fault_filter_count_q[2*f +: 2]) // R7
        2'b00: need[f] = SAMPLES_00;
        2'b01: need[f] = SAMPLES_01;
        2'b10: need[f] = SAMPLES_10;
        default: need[f] = SAMPLES_11;
      endcase
    end

    // A sample that sees the input low restarts the hunt, so all samples are consecutive.
    always_ff @(posedge core_clk) begin
      if (reset) begin
        st_q[f] <= PFG_IDLE;
        tick_q[f] <= 3'h0;
        cnt_q[f] <= 4'h0;
      end else if (!fen[f]) begin // R1
        st_q[f] <= PFG_IDLE;
        tick_q[f] <= 3'h0;
        cnt_q[f] <= 4'h0;
      end else begin
        case (st_q[f])
          PFG_IDLE: begin
            if (fault_input[f] && !fin_q[f]) begin // R2
              st_q[f] <= PFG_WAIT;
              tick_q[f] <= 3'(FIRST_SAMPLE_CYC - 1); // R6
              cnt_q[f] <= 4'h0;
            end
          end
          PFG_WAIT: begin
            if (tick_q[f] != 3'h0) begin
              tick_q[f] <= tick_q[f] - 3'h1;
            end else if (!fault_input[f]) begin // R6
              st_q[f] <= PFG_IDLE;
            end else if (cnt_q[f] + 4'h1 == need[f]) begin // R7
              st_q[f] <= PFG_DONE;
            end else begin
              cnt_q[f] <= cnt_q[f] + 4'h1;
              tick_q[f] <= 3'(NEXT_SAMPLE_CYC - 1); // R6
            end
          end
          PFG_DONE: begin
            if (!fault_input[f]) begin
              st_q[f] <= PFG_IDLE;
            end
          end
          default: st_q[f] <= PFG_IDLE;
        endcase
      end
    end

    // Gating by the enable as well means a disable in mid-count can never set a flag.
    assign qualified[f] = fen[f] && (st_q[f] == PFG_WAIT) && (tick_q[f] == 3'h0) && fault_input[f] // R1
                          && (cnt_q[f] + 4'h1 == need[f]);
  end

  // ********************************************************************
  // Fault flags and interrupts.
  // ********************************************************************
  logic [3:0] clr, fault_clear_select, fault_irq_enable, auto_clr;
  assign fault_clear_select = {fctl_q[7], fctl_q[5], fctl_q[3], fctl_q[1]};
  assign fault_irq_enable = {fctl_q[6], fctl_q[4], fctl_q[2], fctl_q[0]};
  assign clr = (wr_hit && idx == IDX_FAULT_STATUS_FLAGS) ? {wb[6], wb[4], wb[2], wb[0]} : 4'h0;
  // Automatic mode drops the flag once the input has gone quiet.
  assign auto_clr = fault_clear_select & ~fault_input; // R16

  always_comb begin
    flag_d = (flag_q & ~clr & ~auto_clr) | qualified; // R3 R4
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag_q <= 4'h0;
    end else begin
      flag_q <= flag_d; // R2
    end
  end

  logic [3:0] irq_clr;
  assign irq_clr = (wr_hit && idx == IDX_IRQ_STATUS) ? wb[3:0] : 4'h0;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      istat_q <= 4'h0;
    end else begin
      istat_q <= (istat_q & ~irq_clr & ~clr) | (qualified & fault_irq_enable); // R5 R17
    end
  end

  assign irq = |(istat_q & imask_q[3:0] & flag_q); // R5

  // ********************************************************************
  // Pin disable and software override.
  // ********************************************************************
  // The immediate path is combinational from the pin, so it does not wait for qualification.
  logic [3:0] active;
  logic [3:0] map [6];
  logic [5:0] drv;
  assign active = fen & (fault_input | flag_q); // R8 R1
  assign map[0] = dma_q[3:0]; // R10
  assign map[1] = dma_q[7:4];
  assign map[2] = dmb_q[3:0];
  assign map[3] = dmb_q[7:4];
  assign map[4] = dmc_q[3:0];
  assign map[5] = dmc_q[7:4];

  for (genvar p = 0; p < 6; p++) begin : g_pin
    assign pin_disable[p] = |(active & map[p]); // R11 R10
    if (p % 2 == 0) begin : g_even
      assign drv[p] = lvl_q[p]; // R14 R15
    end else begin : g_odd
      assign drv[p] = mode_q[COMPL_BIT] ? (lvl_q[p] & ~lvl_q[p-1]) : lvl_q[p]; // R15 R14 R13
    end
  end

  always_comb begin
    pwm_pins_out.pwm_gen = pwm_pins_in.pwm_gen;
    for (int i = 0; i < 6; i++) begin
      pwm_pins_out.pwm_out[i] = pin_disable[i] ? 1'b0
                               : (ovr_q[i] ? drv[i] : pwm_pins_in.pwm_gen[i]); // R12 R11
    end
  end

  // ********************************************************************
  // Assertions.
  // ********************************************************************
  a_flag_clear_w1c: assert property (@(posedge core_clk) disable iff (reset) // R3
    (clr[0] && !qualified[0]) |=> !flag_q[0]) else $error("Flag not cleared by write one.");
  a_flag_sets_qual: assert property (@(posedge core_clk) disable iff (reset) // R2
    qualified[1] |=> flag_q[1]) else $error("Qualified fault did not set flag.");
  a_disabled_ignored: assert property (@(posedge core_clk) disable iff (reset) // R1
    (fen == 4'h0) |-> pin_disable == 6'h00) else $error("Disabled fault acted.");
  a_immediate_kill: assert property (@(posedge core_clk) disable iff (reset) // R8
    (fen[0] && fault_input[0] && dma_q[0]) |-> pin_disable[0] && !pwm_pins_out.pwm_out[0])
    else $error("Mapped pin not disabled at once.");
  sequence s_edge0;
    fen[0] && fault_filter_count_q[1:0] == 2'b00 && fault_input[0] && !fin_q[0] && st_q[0] == PFG_IDLE;
  endsequence
  sequence s_sample0;
    fen[0] ##1 (fen[0] && fault_input[0] && fault_filter_count_q[1:0] == 2'b00);
  endsequence
  a_single_two_cyc: assert property (@(posedge core_clk) disable iff (reset) // R6 R7
    s_edge0 ##1 s_sample0 |-> qualified[0])
    else $error("Single sample not qualified in two cycles.");
  a_lock_holds_map: assert property (@(posedge core_clk) disable iff (reset) // R9
    locked |=> $stable(dma_q) && $stable(fen_q)) else $error("Locked register changed.");
  a_irq_withdrawn: assert property (@(posedge core_clk) disable iff (reset) // R5
    (clr == 4'hF && qualified == 4'h0) |=> !irq) else $error("Interrupt survived flag clear.");
  a_override_level: assert property (@(posedge core_clk) disable iff (reset) // R12
    (ovr_q[2] && !pin_disable[2]) |-> pwm_pins_out.pwm_out[2] == lvl_q[2])
    else $error("Override level not driven.");
  a_irq_gate_only: assert property (@(posedge core_clk) disable iff (reset) // R17
    (qualified[3] && !fault_irq_enable[3]) |=> flag_q[3] && !istat_q[3]) else $error("Irq enable gated detection.");
  a_compl_odd: assert property (@(posedge core_clk) disable iff (reset) // R15
    (mode_q[COMPL_BIT] && ovr_q[1] && !pin_disable[1]) |-> pwm_pins_out.pwm_out[1] == (lvl_q[1] & ~lvl_q[0]))
    else $error("Odd pin complement wrong.");
  a_lock_sticky: assert property (@(posedge core_clk) disable iff (reset) // R9
    locked |=> locked) else $error("Lock bit dropped without reset.");

  // ********************************************************************
  // Per-fault checks.
  // ********************************************************************
  // Each check runs on every fault input, so whichever input a test drives is covered.
  for (genvar f = 0; f < 4; f++) begin : g_fault_chk
    sequence s_rise;
      fen[f] && fault_input[f] && !fin_q[f] && st_q[f] == PFG_IDLE;
    endsequence
    sequence s_hit5;
      fen[f] && fault_input[f] && fault_filter_count_q[2*f +: 2] == 2'b01;
    endsequence
    sequence s_gap;
      fen[f] [*3];
    endsequence

    // Between samples only the enable matters; a glitch there does not restart the count.
    a_five_samples: assert property (@(posedge core_clk) disable iff (reset) // R7 R6
      s_rise ##1 fen[f] ##1 s_hit5 ##1 s_gap ##1 s_hit5 ##1 s_gap ##1 s_hit5 ##1 s_gap ##1 s_hit5
      ##1 s_gap ##1 s_hit5 |-> qualified[f])
      else $error("Five consecutive samples did not qualify.");

    a_flag_persists: assert property (@(posedge core_clk) disable iff (reset) // R4
      (flag_q[f] && !clr[f] && !auto_clr[f]) |=> flag_q[f])
      else $error("Latched flag dropped without a clear.");

    a_auto_clear: assert property (@(posedge core_clk) disable iff (reset) // R16
      (fault_clear_select[f] && !fault_input[f] && !qualified[f]) |=> !flag_q[f])
      else $error("Automatic clear did not drop the flag.");

    a_disabled_quiet: assert property (@(posedge core_clk) disable iff (reset) // R1
      (!fen[f] && !flag_q[f]) |=> !flag_q[f])
      else $error("Disabled fault latched a flag.");

    a_irq_raised: assert property (@(posedge core_clk) disable iff (reset) // R17
      (qualified[f] && fault_irq_enable[f]) |=> istat_q[f])
      else $error("Enabled fault raised no interrupt status.");

    a_clear_irq: assert property (@(posedge core_clk) disable iff (reset) // R5
      (clr[f] && !qualified[f]) |=> !istat_q[f])
      else $error("Flag clear left interrupt status set.");
  end

  // ********************************************************************
  // Per-pin checks.
  // ********************************************************************
  for (genvar p = 0; p < 6; p++) begin : g_pin_chk
    a_kill_inactive: assert property (@(posedge core_clk) disable iff (reset) // R11
      pin_disable[p] |-> !pwm_pins_out.pwm_out[p])
      else $error("Disabled pin not inactive.");

    a_map_bit_kills: assert property (@(posedge core_clk) disable iff (reset) // R10
      (|(fen & fault_input & map[p])) |-> pin_disable[p])
      else $error("Mapped live fault did not disable its pin.");

    a_gen_passes: assert property (@(posedge core_clk) disable iff (reset) // R12
      (!ovr_q[p] && !pin_disable[p]) |-> pwm_pins_out.pwm_out[p] == pwm_pins_in.pwm_gen[p])
      else $error("Generator output not passed through.");

    a_indep_level: assert property (@(posedge core_clk) disable iff (reset) // R14
      (!mode_q[COMPL_BIT] && ovr_q[p] && !pin_disable[p]) |-> pwm_pins_out.pwm_out[p] == lvl_q[p])
      else $error("Independent override level not driven.");

    if (p % 2 == 1) begin : g_odd_chk
      a_compl_pair: assert property (@(posedge core_clk) disable iff (reset) // R15
        (mode_q[COMPL_BIT] && ovr_q[p] && ovr_q[p-1] && !pin_disable[p] && !pin_disable[p-1])
        |-> pwm_pins_out.pwm_out[p] == (lvl_q[p] & ~pwm_pins_out.pwm_out[p-1]))
        else $error("Odd pin not complement of even pin.");
    end
  end

endmodule

// ==== src/pfg_pkg.sv ====
// Package for the PWM fault guard and software output override block.
package pfg_pkg;

  // ********************************************************************
  // Register word addresses (byte address is four times the index).
  // ********************************************************************
  localparam logic [3:0] IDX_FAULT_CTRL = 4'h4;
  localparam logic [3:0] IDX_FAULT_INPUT_ENABLE = 4'h5;
  localparam logic [3:0] IDX_FAULT_STATUS_FLAGS = 4'h6;
  localparam logic [3:0] IDX_FAULT_SAMPLE_COUNT = 4'h7;
  localparam logic [3:0] IDX_DISABLE_MAP_PAIR_A = 4'h8;
  localparam logic [3:0] IDX_DISABLE_MAP_PAIR_B = 4'h9;
  localparam logic [3:0] IDX_DISABLE_MAP_PAIR_C = 4'hA;
  localparam logic [3:0] IDX_SOFT_OVERRIDE_ENABLE = 4'hB;
  localparam logic [3:0] IDX_LOCK_MODE = 4'hC;
  localparam logic [3:0] IDX_SOFT_DRIVE_LEVEL = 4'hD;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'hE;
  localparam logic [3:0] IDX_IRQ_MASK = 4'hF;

  // ********************************************************************
  // Field positions and reset values.
  // ********************************************************************
  localparam int LOCK_BIT = 0;
  localparam int COMPL_BIT = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ********************************************************************
  // Sampling timing at 125 MHz bus clock, in bus cycles.
  // ********************************************************************
  localparam int FIRST_SAMPLE_CYC = 2;
  localparam int NEXT_SAMPLE_CYC = 4;
  localparam logic [3:0] SAMPLES_00 = 4'h1;
  localparam logic [3:0] SAMPLES_01 = 4'h5;
  localparam logic [3:0] SAMPLES_10 = 4'hA;
  localparam logic [3:0] SAMPLES_11 = 4'hF;

  typedef enum logic [1:0] {
    PFG_IDLE = 2'b00,
    PFG_WAIT = 2'b01,
    PFG_DONE = 2'b10
  } pfg_qual_e;

  typedef struct packed {
    logic [5:0] pwm_gen;
    logic [5:0] pwm_out;
  } pfg_pins_s;

endpackage

// ==== dv/pfg_fault_src.sv ====
// Model of the power-stage fault detectors that drive the fault pins.
`timescale 1ns/1ps
module pfg_fault_src (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic [3:0] lvl,
  output logic [3:0] fault_input = '0
);
  logic [3:0] lag_q [3] = '{default: '0};
  // A slow detector reports both edges four cycles late, two more than a fast one, like a filtered comparator.
  always @(posedge core_clk) begin
    lag_q[0] <= lvl;
    lag_q[1] <= lag_q[0];
    lag_q[2] <= lag_q[1];
    fault_input <= slow ? lag_q[2] : lag_q[0];
  end
endmodule

// ==== dv/pfg_fault_guard_bench.sv ====
// Self-checking bench of the fault guard driven through its register bus and fault pins.
`timescale 1ns/1ps
module pfg_fault_guard_bench;
  import pfg_pkg::*;
  logic core_clk = '0, reset = '1, avs_read = '0, avs_write = '0, prb = '0, slow = '0;
  logic avs_waitrequest, irq;
  logic [5:0] avs_address = '0, gen = '0, pin_disable, dd, o;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic [3:0] fault_req = '0, fault_input;
  logic [7:0] m [3];
  logic [31:0] rd_q [$], pr_q [$];
  pfg_pins_s pin_o;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  pfg_fault_src SRC (.core_clk(core_clk), .slow(slow), .lvl(fault_req), .fault_input(fault_input));
  pfg_fault_guard DUT (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fault_input(fault_input), .pwm_pins_in({gen, 6'h00}),
    .pwm_pins_out(pin_o), .pin_disable(pin_disable), .irq(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // The request is held until waitrequest is seen low, so no answer time is assumed.
  task automatic bus(input logic [3:0] i, input logic w, input logic [7:0] d);
    avs_address <= {i, 2'h0};
    avs_writedata <= {24'h000000, d};
    avs_read <= ~w;
    avs_write <= w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bus(i, 1'h1, d);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    rd_q.push_back({24'h000000, e});
    bus(i, 1'h0, 8'h00);
  endtask
  task automatic probe(input logic q, input logic [5:0] d, input logic [5:0] p);
    pr_q.push_back({13'h0000, gen, q, d, p});
    prb <= 1'h1;
    @(posedge core_clk);
    prb <= 1'h0;
    @(posedge core_clk);
  endtask
  function automatic logic [5:0] pins(input logic [5:0] o, input logic [5:0] l, input logic c);
    logic [5:0] g;
    g = gen;
    for (int i = 0; i < 6; i++)
      if (o[i]) g[i] = (c && i % 2) ? l[i] & ~g[i - 1] : l[i];
    return g;
  endfunction
  function automatic logic [7:0] msk(input logic [3:0] i);
    case (i)
      4'h5, 4'hF: return 8'h0F;
      4'hB, 4'hD: return 8'h3F;
      4'h4, 4'h7, 4'h8, 4'h9, 4'hA: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  initial forever #4 core_clk = ~core_clk;
  // Read data is taken at the rising edge that sees waitrequest low, as a bus master would.
  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'h0) check(avs_readdata, rd_q.pop_front());
  end
  // Pins are judged at the falling edge, where the rising-edge updates have settled.
  always @(negedge core_clk) begin
    if (prb) check({13'h0000, pin_o.pwm_gen, irq, pin_disable, pin_o.pwm_out}, pr_q.pop_front());
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ****************************************************************
  // Stimulus.
  // ****************************************************************
  initial begin
    logic [7:0] v;
    logic [1:0] q;
    int ch, n;
    void'($urandom(32'h287143f3));
    repeat (8) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      if (i != 12) begin
        wr(i[3:0], v);
        rd(i[3:0], v & msk(i[3:0]));
      end
    end
    reset <= 1'h1;
    repeat (8) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    for (int i = 0; i < 16; i++) rd(i[3:0], 8'h00);
    for (int k = 0; k < 6; k++) begin
      gen <= $urandom;
      v = $urandom;
      ch = $urandom;
      o = k[0] ? {{2{ch[2]}}, {2{ch[1]}}, {2{ch[0]}}} : ch[5:0];
      wr(IDX_LOCK_MODE, {6'h00, k[0], 1'h0});
      wr(IDX_SOFT_DRIVE_LEVEL, v);
      wr(IDX_SOFT_OVERRIDE_ENABLE, {2'h0, o});
      probe(1'h0, 6'h00, pins(o, v[5:0], k[0]));
    end
    wr(IDX_SOFT_OVERRIDE_ENABLE, 8'h00);
    for (int k = 0; k < 4; k++) begin
      q = k[1:0];
      n = q ? 5 * q : 1;
      // Each input gets its own sample-count code, so a check that needs one code, such as a_five_samples, is reached on one input only.
      ch = k;
      slow <= q == 2'h1;
      for (int i = 0; i < 3; i++) begin
        m[i] = $urandom | ({7'h00, i == 0} << ch);
        wr(IDX_DISABLE_MAP_PAIR_A + i[3:0], m[i]);
      end
      for (int i = 0; i < 6; i++) dd[i] = m[i / 2][4 * (i % 2) + ch];
      wr(IDX_FAULT_INPUT_ENABLE, 8'h01 << ch);
      wr(IDX_FAULT_SAMPLE_COUNT, {6'h00, q} << 2 * ch);
      wr(IDX_FAULT_CTRL, {6'h00, q == 2'h2, q != 2'h3} << 2 * ch);
      wr(IDX_IRQ_MASK, {7'h00, q != 2'h1} << ch);
      if (q) begin
        fault_req[ch] <= 1'h1;
        repeat (4 * n - 5) @(posedge core_clk);
        fault_req[ch] <= 1'h0;
        repeat (10) @(posedge core_clk);
        rd(IDX_FAULT_STATUS_FLAGS, 8'h00);
      end
      fault_req[ch] <= 1'h1;
      repeat (6) @(posedge core_clk);
      if (q) probe(1'h0, dd, gen & ~dd);
      repeat (4 * n + 4) @(posedge core_clk);
      probe(~q[0], dd, gen & ~dd);
      fault_req[ch] <= 1'h0;
      repeat (8) @(posedge core_clk);
      if (q == 2'h2) begin
        rd(IDX_FAULT_STATUS_FLAGS, 8'h00);
        continue;
      end
      rd(IDX_FAULT_STATUS_FLAGS, 8'h01 << 2 * ch);
      probe(~q[0], dd, gen & ~dd);
      wr(IDX_FAULT_STATUS_FLAGS, 8'h00);
      rd(IDX_FAULT_STATUS_FLAGS, 8'h01 << 2 * ch);
      wr(IDX_FAULT_STATUS_FLAGS, 8'hFF);
      rd(IDX_FAULT_STATUS_FLAGS, 8'h00);
      probe(1'h0, 6'h00, gen);
    end
    wr(IDX_FAULT_INPUT_ENABLE, 8'h00);
    fault_req <= 4'hF;
    repeat (70) @(posedge core_clk);
    probe(1'h0, 6'h00, gen);
    fault_req <= 4'h0;
    rd(IDX_FAULT_STATUS_FLAGS, 8'h00);
    for (int i = 5; i < 11; i++)
      if (i != 6) wr(i[3:0], 8'hA5);
    wr(IDX_LOCK_MODE, 8'h01);
    for (int i = 5; i < 11; i++)
      if (i != 6) begin
        wr(i[3:0], 8'h5A);
        rd(i[3:0], 8'hA5 & msk(i[3:0]));
      end
    wr(IDX_SOFT_DRIVE_LEVEL, 8'h2A);
    rd(IDX_SOFT_DRIVE_LEVEL, 8'h2A);
    repeat (4) @(posedge core_clk);
    complete_run();
  end
endmodule
